/* shared/irq_pin_regs.vh */
// constants for the external interrupt pin unit: register offsets, field positions,
// reset values and timing counts; assumes a byte-wide register port on one clock.
//
// Overview of operation
// R1 - bit 6 turns the internal pull off
// R2 - bit 5 picks falling or rising polarity
// R3 - pull follows polarity: down rising, up falling
// R4 - bit 4 enables the pin request function
// R5 - bit 3 flag shows detected pin event
// R6 - write 1 to bit 2 clears flag
// R7 - level mode keeps flag while pin asserted
// R8 - bit 1 raises cpu request while flagged
// R9 - bit 0 adds level sensing to edges
// R10 - synchronise pin, edges from successive samples
// R11 - reset clears all control bits and flag
`ifndef IRQ_PIN_REGS_VH
`define IRQ_PIN_REGS_VH

// register offsets (byte-wide registers, one address each)
`define ADDR_STATUS_CONTROL 4'h0
`define ADDR_INT_STATUS 4'h1
`define ADDR_INT_MASK 4'h2

// field positions of the status and control register
`define BIT_PULL_DISABLE 6
`define BIT_EDGE_POLARITY 5
`define BIT_PIN_FUNCTION_ENABLE 4
`define BIT_EVENT_FLAG 3
`define BIT_EVENT_ACKNOWLEDGE 2
`define BIT_INTERRUPT_ENABLE 1
`define BIT_DETECTION_MODE 0

// mask of writable control bits: 6, 5, 4, 1, 0
`define CONTROL_WRITE_MASK 8'h73

// reset values
`define RESET_CONTROL 8'h00
`define RESET_INT_MASK 2'h0

// synchroniser depth in clock cycles
`define SYNC_STAGES 2

`endif

/* rtl/sync_stage.v */
// two flip-flop synchroniser for one level input.
// assumes one clock; the first stage is read only by the second.
`timescale 1ns/1ps

module sync_stage (
  input wire clock_in,
  input wire reset_n_in,
  input wire level_in,
  output wire level_out
);
  reg meta_q; // first stage, read only by the second
  reg sync_q; // second stage, safe to use

  // synchronous reset to a constant, then shift the level through
  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= level_in;
      sync_q <= meta_q;
    end
  end

  assign level_out = sync_q;
endmodule

/* rtl/ext_irq_pin.v */
// external interrupt request pin unit: one status and control register,
// pin edge/level detection, pull device control and a cpu request.
// assumes a simple register port, read data one cycle after the read strobe,
// and a pin input that may be asynchronous to clock_in.
`timescale 1ns/1ps
`include "irq_pin_regs.vh"

module ext_irq_pin (
  input wire clock_in,
  input wire reset_n_in,
  input wire [3:0] addr_in,
  input wire [7:0] wdata_in,
  input wire write_in,
  input wire read_in,
  output reg [7:0] rdata_out,
  input wire irq_pin_in,
  output reg pull_up_en_out,
  output reg pull_down_en_out,
  output wire cpu_irq_out,
  output wire irq_out
);

  // control bits
  reg pull_disable_q;
  reg edge_polarity_q;
  reg pin_function_enable_q;
  reg interrupt_enable_q;
  reg detection_mode_q;
  reg event_flag_q;
  reg event_flag_d;

  // interrupt status (sticky, cleared on read) and mask
  // bit 0: event detected, bit 1: acknowledge refused by asserted level
  reg [1:0] int_status_q;
  reg [1:0] int_status_d;
  reg [1:0] int_mask_q;

  // pin sampling
  wire pin_sync; // synchronised pin level
  reg pin_prev_q; // previous synchronised sample
  reg pin_valid_q; // a previous sample exists since enable

  // decoded strobes
  wire wr_ctrl = write_in && (addr_in == `ADDR_STATUS_CONTROL);
  wire wr_mask = write_in && (addr_in == `ADDR_INT_MASK);
  wire rd_stat = read_in && (addr_in == `ADDR_INT_STATUS);
  wire ack = wr_ctrl && wdata_in[`BIT_EVENT_ACKNOWLEDGE]; // R6

  // pin synchroniser
  sync_stage u_sync (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .level_in(irq_pin_in),
    .level_out(pin_sync)
  );

  // pin level in asserted sense: high means the selected polarity is active
  wire pin_asserted = edge_polarity_q ? pin_sync : ~pin_sync; // R2
  wire prev_asserted = edge_polarity_q ? pin_prev_q : ~pin_prev_q;

  // edge found by comparing successive samples; the valid bit stops a
  // false edge when the function is switched on with the pin already active
  wire edge_hit = pin_valid_q && pin_asserted && !prev_asserted; // R10
  wire level_hit = detection_mode_q && pin_asserted; // R9
  wire event_hit = pin_function_enable_q && (edge_hit || level_hit); // R4 R10

  // sample history; the valid bit is cleared while the function is disabled, the previous sample always follows the pin
  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      pin_prev_q <= 1'b0;
      pin_valid_q <= 1'b0;
    end else begin
      pin_prev_q <= pin_sync;
      pin_valid_q <= pin_function_enable_q;
    end
  end

  // event flag: a new event wins over an acknowledge in the same cycle,
  // which also keeps the flag while level mode sees an asserted pin
  always @* begin
    event_flag_d = event_flag_q;
    if (ack) begin
      event_flag_d = 1'b0; // R6
    end
    if (event_hit) begin
      event_flag_d = 1'b1; // R5 R7
    end
  end

  // control register and flag
  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      pull_disable_q <= 1'b0; // R11
      edge_polarity_q <= 1'b0;
      pin_function_enable_q <= 1'b0;
      interrupt_enable_q <= 1'b0;
      detection_mode_q <= 1'b0;
      event_flag_q <= 1'b0;
    end else begin
      event_flag_q <= event_flag_d;
      if (wr_ctrl) begin
        pull_disable_q <= wdata_in[`BIT_PULL_DISABLE]; // R1
        edge_polarity_q <= wdata_in[`BIT_EDGE_POLARITY]; // R2
        pin_function_enable_q <= wdata_in[`BIT_PIN_FUNCTION_ENABLE]; // R4
        interrupt_enable_q <= wdata_in[`BIT_INTERRUPT_ENABLE]; // R8
        detection_mode_q <= wdata_in[`BIT_DETECTION_MODE]; // R9
      end
    end
  end

  // sticky status: set wins over the clear made by reading it
  always @* begin
    int_status_d = int_status_q;
    if (rd_stat) begin
      int_status_d = 2'h0;
    end
    if (event_hit && !event_flag_q) begin
      int_status_d[0] = 1'b1;
    end
    if (ack && event_hit && detection_mode_q) begin
      int_status_d[1] = 1'b1; // R7
    end
  end

  // status and mask registers
  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      int_status_q <= 2'h0;
      int_mask_q <= `RESET_INT_MASK;
    end else begin
      int_status_q <= int_status_d;
      if (wr_mask) begin
        int_mask_q <= wdata_in[1:0];
      end
    end
  end

  // pull device: only with the function on and the pull not disabled
  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      pull_up_en_out <= 1'b0;
      pull_down_en_out <= 1'b0;
    end else begin
      pull_up_en_out <= pin_function_enable_q && !pull_disable_q && !edge_polarity_q; // R1 R3
      pull_down_en_out <= pin_function_enable_q && !pull_disable_q && edge_polarity_q; // R3
    end
  end

  // read data one cycle after the strobe; acknowledge bit reads zero,
  // unmapped addresses read zero, idle cycles hold zero
  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      rdata_out <= 8'h00;
    end else if (read_in) begin
      case (addr_in)
        `ADDR_STATUS_CONTROL: begin
          rdata_out <= {1'b0, pull_disable_q, edge_polarity_q, pin_function_enable_q,
                        event_flag_q, 1'b0, interrupt_enable_q, detection_mode_q}; // R5 R6
        end
        `ADDR_INT_STATUS: begin
          rdata_out <= {6'h00, int_status_q};
        end
        `ADDR_INT_MASK: begin
          rdata_out <= {6'h00, int_mask_q};
        end
        default: begin
          rdata_out <= 8'h00;
        end
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // cpu request follows the flag while enabled
  assign cpu_irq_out = interrupt_enable_q && event_flag_q; // R8
  // summary interrupt from the sticky status register
  assign irq_out = |(int_status_q & int_mask_q);

endmodule

/* verification/ext_irq_pin_props.sv */
// port checker for the interrupt pin unit
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module ext_irq_pin_props(
  input wire clock_in,
  input wire reset_n_in,
  input wire [3:0] addr_in,
  input wire [7:0] wdata_in,
  input wire write_in,
  input wire read_in,
  input wire [7:0] rdata_out,
  input wire irq_pin_in,
  input wire pull_up_en_out,
  input wire pull_down_en_out,
  input wire cpu_irq_out,
  input wire irq_out
);
  logic [7:0] ctrl_q; // shadow of the writable control bits
  wire wr0 = write_in && addr_in == 4'h0; // control write
  wire lvl = ctrl_q[4] && irq_pin_in == ctrl_q[5]; // pin at its asserted level
  // shadow lets outputs be tied to settings without seeing inside
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) ctrl_q <= 8'h00;
    else if (wr0) ctrl_q <= wdata_in & 8'h73;
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  a_ack_zero: assert property (read_in |=> !rdata_out[2]) else $error("ack bit read 1");
  a_ctrl_back: assert property (read_in && addr_in == 4'h0
    |=> (rdata_out & 8'h73) == $past(ctrl_q)) else $error("control readback");
  a_pull_up: assert property ($stable(ctrl_q)
    |-> pull_up_en_out == (ctrl_q[6:4] == 3'b001)) else $error("pull-up wrong");
  a_pull_down: assert property ($stable(ctrl_q)
    |-> pull_down_en_out == (ctrl_q[6:4] == 3'b011)) else $error("pull-down wrong");
  a_edge_flag: assert property ($stable(ctrl_q) && lvl && ctrl_q[1]
    && $changed(irq_pin_in) |-> ##[1:4] cpu_irq_out) else $error("edge missed");
  a_level_hold: assert property ((ctrl_q[0] && lvl)[*4] ##0 wr0
    && wdata_in[2] && wdata_in[1] |=> cpu_irq_out) else $error("level flag lost");
  a_ack_clear: assert property ($stable(irq_pin_in)[*6] ##0 wr0
    && wdata_in[2] && !wdata_in[0] && !ctrl_q[0] |=> !cpu_irq_out) else $error("ack ignored");
  a_reset_out: assert property ($rose(reset_n_in)
    |-> !cpu_irq_out && !irq_out && rdata_out == 8'h00) else $error("reset outputs");
  cover property (cpu_irq_out);
  cover property (irq_out);
  cover property (pull_down_en_out);
endmodule
bind ext_irq_pin ext_irq_pin_props chk(.clock_in, .reset_n_in, .addr_in, .wdata_in, .write_in,
  .read_in, .rdata_out, .irq_pin_in, .pull_up_en_out, .pull_down_en_out, .cpu_irq_out, .irq_out);

/* verification/pin_model.sv */
// far-side device on the request pin
// assumes pull enables come from the unit
`timescale 1ns/1ps
module pin_model(
  input wire clock_in,
  input wire drive_in,
  input wire level_in,
  input wire pu_in,
  input wire pd_in,
  output logic pin_out
);
  logic flt_q = 1'b0; // an unpulled pin wanders every cycle
  always @(posedge clock_in) flt_q <= ~flt_q;
  // the pull only shows while the device lets go
  assign pin_out = drive_in ? level_in : pu_in ? 1'b1 : pd_in ? 1'b0 : flt_q;
endmodule

/* verification/tb_top.sv */
// register-level bench for the interrupt pin unit
// assumes the pin model on the pin and the bound checker
`timescale 1ns/1ps
module tb_top;
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic write_in = 1'b0;
  logic read_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic drv = 1'b1; // device drives the pin
  logic lvl = 1'b0; // level it drives
  wire [7:0] rdata_out;
  wire irq_pin_in, pull_up_en_out, pull_down_en_out, cpu_irq_out, irq_out;
  wire [7:0] outs = {4'h0, irq_out, cpu_irq_out, pull_up_en_out, pull_down_en_out};
  int err_count = 0;
  int total_checks = 0;
  always #5 clock_in = ~clock_in;
  ext_irq_pin DUT(.clock_in, .reset_n_in, .addr_in, .wdata_in, .write_in, .read_in,
    .rdata_out, .irq_pin_in, .pull_up_en_out, .pull_down_en_out, .cpu_irq_out, .irq_out);
  pin_model PIN(.clock_in, .drive_in(drv), .level_in(lvl), .pu_in(pull_up_en_out),
    .pd_in(pull_down_en_out), .pin_out(irq_pin_in));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= d;
    write_in <= 1'b1;
    @(posedge clock_in);
    write_in <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock_in);
    addr_in <= a;
    read_in <= 1'b1;
    @(posedge clock_in);
    read_in <= 1'b0;
    #1;
    chk(rdata_out, exp);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // watchdog: the sequence needs under a hundred cycles
  initial begin
    #20000;
    err_count++;
    summarize;
  end
  initial begin
    repeat (12) @(posedge clock_in);
    reset_n_in <= 1'b1;
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    wr(4'h0, 8'hFF);
    rd(4'h0, 8'h73);
    chk(outs, 8'h00);
    wr(4'h0, 8'h32);
    cyc(2);
    chk(outs, 8'h01);
    lvl <= 1'b1;
    cyc(5);
    chk(outs, 8'h05);
    rd(4'h0, 8'h3A);
    wr(4'h0, 8'h36);
    rd(4'h0, 8'h32);
    wr(4'h0, 8'h33);
    cyc(5);
    wr(4'h0, 8'h37);
    rd(4'h0, 8'h3B);
    lvl <= 1'b0;
    cyc(5);
    wr(4'h0, 8'h37);
    rd(4'h0, 8'h33);
    wr(4'h0, 8'h12);
    cyc(2);
    chk(outs, 8'h02);
    drv <= 1'b0;
    cyc(5);
    rd(4'h0, 8'h12);
    drv <= 1'b1;
    cyc(5);
    chk(outs, 8'h06);
    rd(4'h0, 8'h1A);
    wr(4'h2, 8'h01);
    cyc(1);
    chk(outs, 8'h0E);
    rd(4'h1, 8'h03);
    chk(outs, 8'h06);
    rd(4'h2, 8'h01);
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00);
    wr(4'h0, 8'h04);
    drv <= 1'b0;
    cyc(5);
    chk(outs, 8'h00);
    rd(4'h0, 8'h00);
    summarize;
  end
endmodule
